// *** design/qie_pkg.sv ***
/*
 Package for the quadrature index event unit: register map, field layouts, reset values,
 states and carrier structs.
 Assumes a single 25 MHz system clock and an AHB-Lite register bus.
*/
package qie_pkg;
	localparam int QIE_POS_W = 32;
	// Register byte offsets
	localparam logic [7:0] QIE_OFF_CTRL = 8'h00;
	localparam logic [7:0] QIE_OFF_STATUS = 8'h04;
	localparam logic [7:0] QIE_OFF_POS = 8'h08;
	localparam logic [7:0] QIE_OFF_MAX = 8'h0c;
	localparam logic [7:0] QIE_OFF_IRQ_STAT = 8'h10;
	localparam logic [7:0] QIE_OFF_IRQ_EN = 8'h14;
	localparam logic [7:0] QIE_OFF_IRQ_CLR = 8'h18;
	// Control fields
	localparam int QIE_CTRL_MODE_LSB = 0;
	localparam int QIE_CTRL_EN_BIT = 2;
	localparam logic [1:0] QIE_MODE_EVERY = 2'h0;
	localparam logic [1:0] QIE_MODE_FIRST = 2'h2;
	// Status and interrupt bits
	localparam int QIE_ST_FIRST_BIT = 0;
	localparam int QIE_ST_DIR_BIT = 1;
	localparam int QIE_ST_FWD_BIT = 2;
	localparam int QIE_IRQ_FIRST = 0;
	localparam int QIE_IRQ_RESET = 1;
	localparam int QIE_IRQ_W = 2;
	localparam logic [QIE_POS_W-1:0] QIE_POS_RST = 32'h0000_0000;
	localparam logic [QIE_POS_W-1:0] QIE_MAX_RST = 32'hffff_ffff;
	localparam logic [1:0] QIE_HTRANS_NONSEQ = 2'h2;

	typedef enum logic [1:0] {
		QIE_ST_WAIT = 2'b00,
		QIE_ST_LOCKED = 2'b01
	} qie_state_e;

	typedef struct packed {
		logic phase_a_input;
		logic phase_b_input;
		logic index_input;
	} qie_pins_s;

	typedef struct packed {
		qie_pins_s pins_d1;
		qie_pins_s pins_d2;
		logic [2:0] idx_age;
		logic [1:0] mode;
		logic enable;
		qie_state_e state;
		logic first_index_flag;
		logic first_index_direction_flag;
		logic [1:0] ref_quad;
		logic fwd;
		logic [QIE_POS_W-1:0] position_count;
		logic [QIE_POS_W-1:0] position_max;
		logic [QIE_IRQ_W-1:0] irq_stat;
		logic [QIE_IRQ_W-1:0] irq_en;
		logic ph_sel;
		logic ph_write;
		logic [7:0] ph_addr;
		logic [31:0] hrdata;
	} qie_state_s;
endpackage

// *** design/qie_index_unit.sv ***
/*
 Quadrature position counter with index event reset, first-index marker and an
 AHB-Lite slave holding control, status, position, maximum and interrupt registers.
 Assumes encoder pins are already synchronous to clk and a single bus master.
*/
// The register offsets and the AHB-Lite interface to the registers were left to the implementer.
`timescale 1ns/1ns
module qie_index_unit
	import qie_pkg::*;
#(
	parameter int IDX_WIN = 3
)
(
	// System
	input wire logic clk,
	input wire logic srst,
	// Encoder pins
	input wire qie_pins_s enc_pins,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	// Status out
	output logic [QIE_POS_W-1:0] position_count,
	output logic first_index_flag,
	output logic irq
);
	qie_state_s s_reg;
	qie_state_s s_next;

	logic [1:0] quad_prev;
	logic [1:0] quad_now;
	logic quad_step;
	logic step_fwd;
	logic step_back;
	logic idx_rise;
	logic idx_event;
	logic idx_pending;
	logic first_hit;
	logic do_reset;
	logic [QIE_IRQ_W-1:0] ev;
	logic wr_ctrl;

	always_comb
	begin
		quad_prev = {s_reg.pins_d2.phase_a_input, s_reg.pins_d2.phase_b_input};
		quad_now = {s_reg.pins_d1.phase_a_input, s_reg.pins_d1.phase_b_input};
		quad_step = (quad_prev != quad_now);
		// Gray order 00-10-11-01 is forward
		step_fwd = quad_step && ({quad_prev, quad_now} == 4'b0010 ||
			{quad_prev, quad_now} == 4'b1011 || {quad_prev, quad_now} == 4'b1101 ||
			{quad_prev, quad_now} == 4'b0100);
		step_back = quad_step && !step_fwd;
		idx_rise = s_reg.pins_d1.index_input && !s_reg.pins_d2.index_input;
		// Index stays armed a few clocks so a phase edge shortly after it still pairs
		idx_pending = idx_rise || (s_reg.idx_age != 3'h0);
		first_hit = (s_reg.state == QIE_ST_WAIT) && idx_pending && quad_step;
		idx_event = first_hit || ((s_reg.state == QIE_ST_LOCKED) &&
			s_reg.pins_d1.index_input && quad_step && quad_now == s_reg.ref_quad);
		do_reset = s_reg.enable && idx_event && ((s_reg.mode == QIE_MODE_EVERY) ||
			((s_reg.mode == QIE_MODE_FIRST) && first_hit));
		wr_ctrl = s_reg.ph_sel && s_reg.ph_write && s_reg.ph_addr == QIE_OFF_CTRL;
		ev = '0;

		s_next = s_reg;
		s_next.pins_d1 = enc_pins;
		s_next.pins_d2 = s_reg.pins_d1;
		if (idx_rise)
			s_next.idx_age = 3'(IDX_WIN);
		else if (s_reg.idx_age != 3'h0)
			s_next.idx_age = s_reg.idx_age - 3'h1;
		if (first_hit)
			s_next.idx_age = 3'h0;

		if (step_fwd)
			s_next.fwd = 1'b1;
		else if (step_back)
			s_next.fwd = 1'b0;

		// Position counting and index reset
		if (s_reg.enable && step_fwd)
			s_next.position_count = (s_reg.position_count >= s_reg.position_max) ?
				QIE_POS_RST : s_reg.position_count + 32'h1;
		else if (s_reg.enable && step_back)
			s_next.position_count = (s_reg.position_count == QIE_POS_RST) ?
				s_reg.position_max : s_reg.position_count - 32'h1;
		if (do_reset)
		begin
			if (step_fwd)
				s_next.position_count = QIE_POS_RST;
			else
				s_next.position_count = s_reg.position_max;
			ev[QIE_IRQ_RESET] = 1'b1;
		end

		// Reconfiguration rearms the first-index search; a same-cycle first hit wins
		if (wr_ctrl)
		begin
			s_next.state = QIE_ST_WAIT;
			s_next.first_index_flag = 1'b0;
			s_next.first_index_direction_flag = 1'b0;
		end
		if (s_reg.enable && first_hit)
		begin
			s_next.state = QIE_ST_LOCKED;
			s_next.ref_quad = quad_now;
			s_next.first_index_flag = 1'b1;
			s_next.first_index_direction_flag = step_fwd;
			ev[QIE_IRQ_FIRST] = 1'b1;
		end

		// Register writes in data phase
		if (s_reg.ph_sel && s_reg.ph_write)
		begin
			case (s_reg.ph_addr)
				QIE_OFF_CTRL:
				begin
					s_next.mode = hwdata[QIE_CTRL_MODE_LSB +: 2];
					s_next.enable = hwdata[QIE_CTRL_EN_BIT];
				end
				QIE_OFF_POS: s_next.position_count = hwdata;
				QIE_OFF_MAX: s_next.position_max = hwdata;
				QIE_OFF_IRQ_EN: s_next.irq_en = hwdata[QIE_IRQ_W-1:0];
				default: ;
			endcase
		end
		// Clear first, set wins
		if (s_reg.ph_sel && s_reg.ph_write && s_reg.ph_addr == QIE_OFF_IRQ_CLR)
			s_next.irq_stat = s_reg.irq_stat & ~hwdata[QIE_IRQ_W-1:0];
		s_next.irq_stat = s_next.irq_stat | ev;

		// Address phase capture
		s_next.ph_sel = hsel && hready && htrans == QIE_HTRANS_NONSEQ;
		s_next.ph_write = hwrite;
		s_next.ph_addr = haddr[7:0];
		s_next.hrdata = '0;
		if (hsel && hready && htrans == QIE_HTRANS_NONSEQ && !hwrite)
		begin
			case (haddr[7:0])
				QIE_OFF_CTRL:
					s_next.hrdata = {29'h0, s_next.enable, s_next.mode};
				QIE_OFF_STATUS:
					s_next.hrdata = {29'h0, s_reg.fwd, s_reg.first_index_direction_flag,
						s_reg.first_index_flag};
				QIE_OFF_POS: s_next.hrdata = s_reg.position_count;
				QIE_OFF_MAX: s_next.hrdata = s_reg.position_max;
				QIE_OFF_IRQ_STAT: s_next.hrdata = {30'h0, s_reg.irq_stat};
				QIE_OFF_IRQ_EN: s_next.hrdata = {30'h0, s_reg.irq_en};
				default: s_next.hrdata = '0;
			endcase
		end
	end

	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			s_reg <= '0;
			s_reg.state <= QIE_ST_WAIT;
			s_reg.position_count <= QIE_POS_RST;
			s_reg.position_max <= QIE_MAX_RST;
		end
		else
			s_reg <= s_next;
	end

	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign hrdata = s_reg.hrdata;
	assign position_count = s_reg.position_count;
	assign first_index_flag = s_reg.first_index_flag;
	assign irq = |(s_reg.irq_stat & s_reg.irq_en);
endmodule

// *** test/qie_index_unit_asserts.sv ***
/*
 Port checker for the quadrature index unit.
 Assumes one clock domain and the bind at the foot of this file.
*/
`timescale 1ns/1ns
module qie_index_unit_asserts
	import qie_pkg::*;
(
	// Watched ports
	input wire logic clk,
	input wire logic srst,
	input wire qie_pins_s enc_pins,
	input wire logic hsel,
	input wire logic hwrite,
	input wire logic [1:0] htrans,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic first_index_flag,
	input wire logic [31:0] hrdata,
	input wire logic [QIE_POS_W-1:0] position_count
);
	logic [2:0] age_reg;
	always_ff @(posedge clk)
		age_reg <= enc_pins.index_input ? 3'h0 :
			(srst || age_reg == 3'h7) ? 3'h7 : age_reg + 3'h1;
	default clocking @(posedge clk); endclocking
	default disable iff (srst);
	sequence s_idx_recent;
		age_reg < 3'h7;
	endsequence
	sequence s_wr_req;
		hsel && hwrite && htrans == QIE_HTRANS_NONSEQ;
	endsequence
	sequence s_quiet;
		(!hsel && $stable({enc_pins.phase_a_input, enc_pins.phase_b_input})) [*3];
	endsequence
	property p_flag_sticky;
		first_index_flag && !$past(hsel && hwrite && htrans == QIE_HTRANS_NONSEQ)
			|=> first_index_flag;
	endproperty
	property p_rdata_idle;
		!$past(hsel && !hwrite && htrans == QIE_HTRANS_NONSEQ) |-> hrdata == 32'h0;
	endproperty
	property p_pos_hold;
		s_quiet |=> $stable(position_count);
	endproperty
	property p_bus_ok;
		hreadyout && !hresp;
	endproperty
	property p_flag_hold;
		$fell(first_index_flag) |-> $past(hsel && hwrite && htrans == QIE_HTRANS_NONSEQ, 2);
	endproperty
	property p_flag_cause;
		$rose(first_index_flag) |-> s_idx_recent;
	endproperty
	a_bus_ok: assert property (p_bus_ok)
		else $error("bus answer not zero-wait okay");
	a_flag_hold: assert property (p_flag_hold)
		else $error("first index flag dropped without a write");
	a_flag_cause: assert property (p_flag_cause)
		else $error("first index flag set with no recent index");
	a_flag_sticky: assert property (p_flag_sticky)
		else $error("first index flag lost with no control write");
	a_rdata_idle: assert property (p_rdata_idle)
		else $error("read data not zero outside a read data phase");
	a_pos_hold: assert property (p_pos_hold)
		else $error("position moved with no phase step or write");
endmodule
bind qie_index_unit qie_index_unit_asserts u_chk (.clk, .srst, .enc_pins, .hsel, .hwrite,
	.htrans, .hreadyout, .hresp, .first_index_flag, .hrdata, .position_count);

// *** test/qie_enc_model.sv ***
/*
 Incremental encoder model with index output.
 Assumes tasks are called right after a rising clock edge.
*/
`timescale 1ns/1ns
module qie_enc_model
	import qie_pkg::*;
(
	// Clock and pins
	input wire logic clk,
	output qie_pins_s pins
);
	int q = 0;
	initial pins = '0;
	// One step, three clocks (four for negative d); index at offset d, 9 for none
	task automatic move(input int dir, input int d);
		for (int c = (d < 0) ? -1 : 0; c < 3; c++)
		begin
			pins.index_input <= (c >= d);
			if (c == 0)
			begin
				q = (q + dir) & 3;
				pins.phase_a_input <= (q == 1 || q == 2);
				pins.phase_b_input <= (q >= 2);
			end
			@(posedge clk);
		end
	endtask
endmodule

// *** test/test_qie_index_unit.sv ***
/*
 Self-checking bench for the quadrature index unit.
 Assumes the encoder model and the port checker.
*/
`timescale 1ns/1ns
module test_qie_index_unit
	import qie_pkg::*;
;
	logic clk = 0;
	logic srst = 1;
	logic hsel = 0;
	logic hwrite = 0;
	logic [1:0] htrans = 2'h0;
	logic [31:0] haddr = 0, hwdata = 0, rd, m, e, x = 32'h859f;
	logic hreadyout, hresp, first_index_flag, irq;
	logic [31:0] hrdata, position_count;
	qie_pins_s pins;
	int n_mismatch = 0, check_count = 0, cyc = 0, md, dir;
	always #20 clk = ~clk;
	qie_enc_model u_enc (.clk(clk), .pins(pins));
	qie_index_unit u_dut (.clk(clk), .srst(srst), .enc_pins(pins), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .irq(irq),
		.position_count(position_count), .first_index_flag(first_index_flag));
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic end_sim;
		$display("checks %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		hwrite <= w;
		htrans <= QIE_HTRANS_NONSEQ;
		@(posedge clk);
		while (hreadyout !== 1'b1) @(posedge clk);
		htrans <= 2'h0;
		hsel <= 1'b0;
		hwdata <= d;
		@(posedge clk);
		while (hreadyout !== 1'b1) @(posedge clk);
		rd = hrdata;
	endtask
	task automatic irq_step(input logic [7:0] a, input logic [31:0] d, input logic exp);
		bus(1'b1, a, d);
		@(posedge clk);
		chk(32'(irq), 32'(exp));
	endtask
	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 3000)
		begin
			n_mismatch++;
			end_sim;
		end
	end
	initial
	begin
		repeat (10) @(posedge clk);
		srst <= 1'b0;
		@(posedge clk);
		bus(1'b0, QIE_OFF_MAX, 0);
		chk(rd, QIE_MAX_RST);
		bus(1'b0, 8'h40, 0);
		chk(rd, 32'h0);
		x ^= x << 13;
		x ^= x >> 17;
		x ^= x << 5;
		m = x | 32'h100;
		bus(1'b1, QIE_OFF_MAX, m);
		bus(1'b1, QIE_OFF_IRQ_EN, 32'h1);
		for (int i = 0; i < 4; i++)
		begin
			md = (i < 2) ? 0 : 2;
			dir = i[0] ? -1 : 1;
			bus(1'b1, QIE_OFF_CTRL, 32'(md | 4));
			@(posedge clk);
			chk(32'(first_index_flag), 32'h0);
			for (int k = 0; k < 3; k++) u_enc.move(dir, k == 2 ? 0 : 9);
			repeat (4) @(posedge clk);
			e = (dir > 0) ? 32'h0 : m;
			chk(position_count, e);
			chk(32'(first_index_flag), 32'h1);
			for (int k = 0; k < 4; k++) u_enc.move(dir, k == 3 ? 0 : 9);
			repeat (4) @(posedge clk);
			chk(position_count, md == 0 ? e : e + 32'(4 * dir));
		end
		for (int d = -1; d < 3; d++)
		begin
			bus(1'b1, QIE_OFF_CTRL, 32'h6);
			for (int k = 0; k < 4; k++) u_enc.move(1, k == 1 ? d : 9);
			bus(1'b0, QIE_OFF_STATUS, 0);
			chk(rd & 32'h7, 32'h7);
		end
		chk(32'(irq), 32'h1);
		irq_step(QIE_OFF_IRQ_EN, 32'h0, 1'b0);
		irq_step(QIE_OFF_IRQ_EN, 32'h1, 1'b1);
		irq_step(QIE_OFF_IRQ_CLR, 32'h3, 1'b0);
		end_sim;
	end
endmodule
